//--- rtl/acs_pkg.sv
// package of constants and types for the conversion sequencer
package acs_pkg;
	localparam int unsigned CLK_MHZ       = 100;
	localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
	// register offsets (4-bit address port)
	localparam logic [3:0] ADDR_CTRL      = 4'h0;
	localparam logic [3:0] ADDR_PORTCFG   = 4'h1;
	localparam logic [3:0] ADDR_RES_HI    = 4'h2;
	localparam logic [3:0] ADDR_RES_LO    = 4'h3;
	localparam logic [3:0] ADDR_STATUS    = 4'h4;
	localparam logic [3:0] ADDR_PORT_RD   = 4'h5;
	localparam logic [3:0] ADDR_DIR       = 4'h6;
	localparam logic [3:0] ADDR_PORT_OUT  = 4'h7;
	// control register fields
	localparam int unsigned CTRL_SRC_POS  = 6;
	localparam int unsigned CTRL_CHAN_POS = 3;
	localparam int unsigned CTRL_GO_POS   = 2;
	localparam int unsigned CTRL_PWR_POS  = 0;
	// port config register fields
	localparam int unsigned CFG_JUST_POS  = 5;
	// status register fields
	localparam int unsigned STAT_DONE_POS = 0;
	localparam int unsigned STAT_INV_POS  = 1;
	// reset values
	localparam logic [7:0] CTRL_RESET     = 8'h00;
	localparam logic [7:0] CFG_RESET      = 8'h00;
	localparam logic [7:0] DIR_RESET      = 8'hFF;
	// tick sources
	localparam logic [1:0] SRC_DIV2       = 2'h0;
	localparam logic [1:0] SRC_DIV8       = 2'h1;
	localparam logic [1:0] SRC_DIV32      = 2'h2;
	localparam logic [1:0] SRC_RC         = 2'h3;
	localparam int unsigned DIV2          = 2;
	localparam int unsigned DIV8          = 8;
	localparam int unsigned DIV32         = 32;
	// timing: conversion and holdoff in half periods of the bit conversion period, minimum period in ns and clock cycles
	localparam int unsigned RESULT_BITS   = 10;
	localparam int unsigned CONV_HALVES   = 23;
	localparam int unsigned HOLD_HALVES   = 4;
	localparam int unsigned MIN_PERIOD_NS = 1600;
	localparam int unsigned MIN_PERIOD_CYC =
		(MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		ACS_OFF,
		ACS_ACQUIRE,
		ACS_CONVERT,
		ACS_HOLDOFF
	} acs_state_t;
endpackage

//--- rtl/acs_tick_gen.sv
// half-period tick generator: oscillator division or rc clock edges
`timescale 1ns/1ns
`default_nettype none
module acs_tick_gen
	import acs_pkg::*;
(
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// control
	input  wire logic       run_in,
	input  wire logic [1:0] src_in,
	input  wire logic       rc_clk_in,
	// ticks
	output logic            half_tick_out,
	output logic [5:0]      period_cyc_out
);
	import acs_pkg::*;

	logic [4:0] div_cnt;
	logic [4:0] half_len;
	logic       rc_meta;
	logic       rc_sync;
	logic       rc_last;

	always_comb begin
		if (src_in == SRC_DIV2) begin
			half_len = 5'(DIV2 / 2);
		end else if (src_in == SRC_DIV8) begin
			half_len = 5'(DIV8 / 2);
		end else begin
			half_len = 5'(DIV32 / 2);
		end
	end

	// each half period restarts the divider, so a mid-conversion switch takes effect at once
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			div_cnt <= 5'h00;
		end else if (!run_in || src_in == SRC_RC || div_cnt + 5'h01 >= half_len) begin
			div_cnt <= 5'h00;
		end else begin
			div_cnt <= div_cnt + 5'h01;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rc_meta <= 1'b0;
			rc_sync <= 1'b0;
			rc_last <= 1'b0;
		end else begin
			rc_meta <= rc_clk_in;
			rc_sync <= rc_meta;
			rc_last <= rc_sync;
		end
	end

	always_comb begin
		if (!run_in) begin
			half_tick_out = 1'b0;
		end else if (src_in == SRC_RC) begin
			half_tick_out = rc_sync ^ rc_last;
		end else begin
			half_tick_out = (div_cnt + 5'h01 >= half_len);
		end
	end

	assign period_cyc_out = {half_len, 1'b0};
endmodule
`default_nettype wire

//--- rtl/acs_sequencer.sv
// conversion sequencer for a 10-bit successive-approximation converter
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer
	import acs_pkg::*;
(
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// register port
	input  wire logic [3:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic [7:0]      rdata_out,
	// converter clock
	input  wire logic       rc_clk_in,
	// analog front end
	output logic [2:0]      mux_sel_out,
	output logic            sample_connect_out,
	output logic            dac_drive_own_out,
	output logic [9:0]      dac_code_out,
	input  wire logic       comp_in,
	output logic            powered_out,
	// port pins
	input  wire logic [7:0] pin_in,
	output logic [7:0]      pin_out,
	output logic [7:0]      pin_oe_out,
	// events
	output logic            conversion_done_flag_out
);
	import acs_pkg::*;

	acs_state_t state;
	logic [1:0] tick_source_select;
	logic [2:0] input_channel_select;
	logic       go_flag;
	logic       converter_power_bit;
	logic       result_justify_bit;
	logic [3:0] port_config_control;
	logic [7:0] pin_direction_bit;
	logic [7:0] port_latch;
	logic [15:0] result_pair;
	logic [9:0] sar;
	logic [4:0] half_cnt;
	logic       conversion_done_flag;
	logic       bits_invalid;
	logic       half_tick;
	logic [5:0] period_cyc;
	logic [7:0] pin_meta;
	logic [7:0] pin_sync;
	logic       comp_meta;
	logic       comp_sync;
	logic [7:0] analog_mask;
	logic       wr_ctrl;
	logic       sw_go;
	logic       sw_abort;
	logic [3:0] bit_idx;

	// analog pin map from port configuration
	function automatic logic [7:0] analog_map(input logic [3:0] cfg);
		logic [7:0] m;
		m = 8'h00;
		case (cfg)
			4'h0: m = 8'hFF;
			4'h1: m = 8'hF7;
			4'h2: m = 8'h1F;
			4'h3: m = 8'h17;
			4'h4: m = 8'h0B;
			4'h5: m = 8'h03;
			4'h8: m = 8'hF3;
			4'h9: m = 8'h3F;
			4'hA: m = 8'h37;
			4'hB: m = 8'h33;
			4'hC: m = 8'h13;
			4'hD: m = 8'h03;
			4'hE: m = 8'h01;
			4'hF: m = 8'h01;
			default: m = 8'h00;
		endcase
		return m;
	endfunction

	assign analog_mask = analog_map(port_config_control);
	assign wr_ctrl = wr_in && addr_in == ADDR_CTRL;
	assign sw_go = wr_ctrl && wdata_in[CTRL_GO_POS] && converter_power_bit;
	assign sw_abort = wr_ctrl && !wdata_in[CTRL_GO_POS] && state == ACS_CONVERT;

	acs_tick_gen u_tick (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.run_in        (converter_power_bit),
		.src_in        (tick_source_select),
		.rc_clk_in     (rc_clk_in),
		.half_tick_out (half_tick),
		.period_cyc_out(period_cyc)
	);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
			comp_meta <= 1'b0;
			comp_sync <= 1'b0;
		end else begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
			comp_meta <= comp_in;
			comp_sync <= comp_meta;
		end
	end

	// configuration registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tick_source_select <= CTRL_RESET[CTRL_SRC_POS +: 2];
			input_channel_select <= CTRL_RESET[CTRL_CHAN_POS +: 3];
			converter_power_bit <= CTRL_RESET[CTRL_PWR_POS];
			result_justify_bit <= CFG_RESET[CFG_JUST_POS];
			port_config_control <= CFG_RESET[3:0];
			pin_direction_bit <= DIR_RESET;
			port_latch <= 8'h00;
		end else if (wr_in) begin
			if (addr_in == ADDR_CTRL) begin
				tick_source_select <= wdata_in[CTRL_SRC_POS +: 2];
				input_channel_select <= wdata_in[CTRL_CHAN_POS +: 3];
				converter_power_bit <= wdata_in[CTRL_PWR_POS];
			end else if (addr_in == ADDR_PORTCFG) begin
				result_justify_bit <= wdata_in[CFG_JUST_POS];
				port_config_control <= wdata_in[3:0];
			end else if (addr_in == ADDR_DIR) begin
				pin_direction_bit <= wdata_in;
			end else if (addr_in == ADDR_PORT_OUT) begin
				port_latch <= wdata_in;
			end
		end
	end

	// sequencer state, in half-period units
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= ACS_OFF;
			half_cnt <= 5'h00;
		end else if (!converter_power_bit) begin
			state <= ACS_OFF;
			half_cnt <= 5'h00;
		end else begin
			case (state)
				ACS_OFF: begin
					state <= ACS_ACQUIRE;
					half_cnt <= 5'h00;
				end
				ACS_ACQUIRE: begin
					// acquisition length is software's concern, fixed by no resolution
					if (sw_go) begin
						state <= ACS_CONVERT;
						half_cnt <= 5'h00;
					end
				end
				ACS_CONVERT: begin
					if (sw_abort) begin
						state <= ACS_HOLDOFF;
						half_cnt <= 5'h00;
					end else if (half_tick) begin
						if (half_cnt == 5'(CONV_HALVES - 1)) begin
							state <= ACS_HOLDOFF;
							half_cnt <= 5'h00;
						end else begin
							half_cnt <= half_cnt + 5'h01;
						end
					end
				end
				ACS_HOLDOFF: begin
					if (half_tick) begin
						if (half_cnt == 5'(HOLD_HALVES - 1)) begin
							state <= ACS_ACQUIRE;
							half_cnt <= 5'h00;
						end else begin
							half_cnt <= half_cnt + 5'h01;
						end
					end
				end
				default: state <= ACS_OFF;
			endcase
		end
	end

	// first period samples; bit k resolved at end of period k+1
	assign bit_idx = 4'(half_cnt >> 1);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sar <= 10'h000;
			bits_invalid <= 1'b0;
		end else if (state == ACS_ACQUIRE && sw_go) begin
			sar <= 10'h200;
			bits_invalid <= 1'b0;
		end else if (state == ACS_CONVERT && half_tick && half_cnt[0]
			&& bit_idx >= 4'h1 && bit_idx <= 4'(RESULT_BITS)) begin
			// msb first: keep or drop trial bit, then try next
			sar[4'(RESULT_BITS) - bit_idx] <= comp_sync;
			if (bit_idx < 4'(RESULT_BITS)) begin
				sar[4'(RESULT_BITS - 1) - bit_idx] <= 1'b1;
			end
			// too short a period spoils this and all later bits
			// widened compare: the minimum does not fit the period's own width
			if (8'(period_cyc) < 8'(MIN_PERIOD_CYC) && tick_source_select != SRC_RC) begin
				bits_invalid <= 1'b1;
			end
		end
	end

	// go flag: set by software, cleared by completion or abort
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			go_flag <= 1'b0;
		end else if (!converter_power_bit) begin
			go_flag <= 1'b0;
		end else if (state == ACS_ACQUIRE && sw_go) begin
			go_flag <= 1'b1;
		end else if (state != ACS_CONVERT) begin
			go_flag <= 1'b0;
		end else if (sw_abort || (half_tick && half_cnt == 5'(CONV_HALVES - 1))) begin
			go_flag <= 1'b0;
		end
	end

	// result pair and done flag; abort never reaches the load
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			result_pair <= 16'h0000;
		end else if (state == ACS_CONVERT && !sw_abort && half_tick
			&& half_cnt == 5'(CONV_HALVES - 1)) begin
			if (result_justify_bit) begin
				result_pair <= {6'h00, sar};
			end else begin
				result_pair <= {sar, 6'h00};
			end
		end else if (wr_in && addr_in == ADDR_RES_HI) begin
			result_pair[15:8] <= wdata_in;
		end else if (wr_in && addr_in == ADDR_RES_LO) begin
			result_pair[7:0] <= wdata_in;
		end
	end

	// set wins over a software clear in the same cycle
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			conversion_done_flag <= 1'b0;
		end else if (state == ACS_CONVERT && !sw_abort && half_tick
			&& half_cnt == 5'(CONV_HALVES - 1)) begin
			conversion_done_flag <= 1'b1;
		end else if (wr_in && addr_in == ADDR_STATUS && wdata_in[STAT_DONE_POS]) begin
			conversion_done_flag <= 1'b0;
		end
	end

	// read port, one cycle latency
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			if (addr_in == ADDR_CTRL) begin
				rdata_out <= {tick_source_select, input_channel_select, go_flag,
					1'b0, converter_power_bit};
			end else if (addr_in == ADDR_PORTCFG) begin
				rdata_out <= {2'h0, result_justify_bit, 1'b0, port_config_control};
			end else if (addr_in == ADDR_RES_HI) begin
				rdata_out <= result_pair[15:8];
			end else if (addr_in == ADDR_RES_LO) begin
				rdata_out <= result_pair[7:0];
			end else if (addr_in == ADDR_STATUS) begin
				rdata_out <= {6'h00, bits_invalid, conversion_done_flag};
			end else if (addr_in == ADDR_PORT_RD) begin
				rdata_out <= pin_sync & ~analog_mask;
			end else if (addr_in == ADDR_DIR) begin
				rdata_out <= pin_direction_bit;
			end else if (addr_in == ADDR_PORT_OUT) begin
				rdata_out <= port_latch;
			end else begin
				rdata_out <= 8'h00;
			end
		end
	end

	// front end: channel and direction only steer the mux, never the sequence
	assign mux_sel_out = input_channel_select;
	assign sample_connect_out = (state == ACS_ACQUIRE);
	assign dac_drive_own_out = !pin_direction_bit[input_channel_select];
	assign dac_code_out = sar;
	assign powered_out = converter_power_bit;
	assign pin_out = port_latch;
	assign pin_oe_out = ~pin_direction_bit;
	assign conversion_done_flag_out = conversion_done_flag;

	// completion takes exactly 23 half ticks unless aborted
	conv_time_a: assert property (@(posedge clk_in) disable iff (rst_in)
		state == ACS_CONVERT && half_tick && half_cnt == 5'(CONV_HALVES - 1) && !sw_abort
		&& converter_power_bit |=> conversion_done_flag && !go_flag && state == ACS_HOLDOFF)
		else $error("completion did not set done and clear go");
	abort_keep_a: assert property (@(posedge clk_in) disable iff (rst_in)
		sw_abort && converter_power_bit |=> result_pair == $past(result_pair))
		else $error("abort changed result pair");
	abort_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
		sw_abort && converter_power_bit |=> state == ACS_HOLDOFF && !go_flag)
		else $error("abort not immediate");
	hold_disc_a: assert property (@(posedge clk_in) disable iff (rst_in)
		state == ACS_HOLDOFF |-> !sample_connect_out)
		else $error("capacitor connected during holdoff");
	hold_exit_a: assert property (@(posedge clk_in) disable iff (rst_in)
		state == ACS_HOLDOFF && half_tick && half_cnt == 5'(HOLD_HALVES - 1)
		&& converter_power_bit |=> state == ACS_ACQUIRE && sample_connect_out)
		else $error("no automatic acquisition after holdoff");
	port_low_a: assert property (@(posedge clk_in) disable iff (rst_in)
		rd_in && addr_in == ADDR_PORT_RD |=> (rdata_out & $past(analog_mask)) == 8'h00)
		else $error("analog pin read high");
	right_just_a: assert property (@(posedge clk_in) disable iff (rst_in)
		$changed(result_pair) && !$past(wr_in) && $past(result_justify_bit)
		|-> result_pair[15:10] == 6'h00)
		else $error("right justify upper bits not zero");
	power_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!converter_power_bit |=> !go_flag)
		else $error("go set while unpowered");
	go_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
		state == ACS_ACQUIRE && sw_go |=> go_flag ##1 (go_flag || state != ACS_CONVERT))
		else $error("go flag not held during conversion");
endmodule
`default_nettype wire

//--- verification/acs_front_model.sv
// behavioural analog front end: input mux, holding capacitor, comparator
`timescale 1ns/1ns
`default_nettype none
module acs_front_model (
	// clock
	input  wire logic        clk_in,
	// channel levels, ten bits per channel
	input  wire logic [79:0] level_in,
	// from the sequencer
	input  wire logic [2:0]  mux_sel_in,
	input  wire logic        sample_connect_in,
	input  wire logic        drive_own_in,
	input  wire logic [7:0]  pin_level_in,
	input  wire logic [9:0]  dac_code_in,
	input  wire logic        powered_in,
	// to the sequencer
	output logic             comp_out
);
	logic [9:0] held = 10'h000;
	logic [9:0] chan_level;
	logic       wander = 1'b0;

	always_comb begin
		chan_level = level_in[mux_sel_in * 10 +: 10];
		if (drive_own_in)
			chan_level = {10{pin_level_in[mux_sel_in]}};
	end
	// charge stays on the capacitor while disconnected, never drained
	always @(posedge clk_in) begin
		if (sample_connect_in)
			held <= chan_level;
		wander <= ~wander;
	end
	// unpowered comparator gives no usable level
	assign comp_out = powered_in ? (held >= dac_code_in) : wander;
endmodule
`default_nettype wire

//--- verification/acs_sequencer_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer_tb;
	import acs_pkg::*;
	typedef struct packed {logic [7:0] val; logic [7:0] mask;} acs_note_t;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic        rc_clk_in = 1'b0;
	logic [3:0]  addr_in = 4'h0;
	logic [7:0]  wdata_in = 8'h00;
	logic [7:0]  ext_pins = 8'h00;
	logic [79:0] levels = '0;
	logic [7:0]  rdata_out, pin_in, pin_out, pin_oe_out;
	logic [2:0]  mux_sel_out, ch;
	logic [9:0]  dac_code_out, last_res;
	logic        sample_connect_out, dac_drive_own_out, comp_in, powered_out;
	logic        conversion_done_flag_out, last_just, rd_q = 1'b0;
	acs_note_t   notes[$];
	acs_note_t   cur_note;
	int          error_cnt = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          fast_n = 0;

	initial forever #5 clk_in = ~clk_in;
	// rc oscillator at its own rate and phase
	initial begin
		#3;
		forever #157 rc_clk_in = ~rc_clk_in;
	end
	assign pin_in = (pin_oe_out & pin_out) | (~pin_oe_out & ext_pins);

	acs_sequencer dut_u (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
		.rc_clk_in, .mux_sel_out, .sample_connect_out, .dac_drive_own_out, .dac_code_out,
		.comp_in, .powered_out, .pin_in, .pin_out, .pin_oe_out, .conversion_done_flag_out);
	acs_front_model model_u (.clk_in, .level_in(levels), .mux_sel_in(mux_sel_out),
		.sample_connect_in(sample_connect_out), .drive_own_in(dac_drive_own_out),
		.pin_level_in(pin_out), .dac_code_in(dac_code_out), .powered_in(powered_out),
		.comp_out(comp_in));

	task automatic check(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// read data stand from the cycle after the strobe until the next read
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		rd_q <= rd_in;
		if (rd_q) begin
			cur_note = notes.pop_front();
			check((rdata_out & cur_note.mask) === (cur_note.val & cur_note.mask), "read data");
		end
		if (cyc == 20000) begin
			check(1'b0, "timeout");
			finish_test();
		end
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] v, input logic [7:0] m);
		@(posedge clk_in);
		notes.push_back('{v, m});
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
	endtask
	task automatic rd_res(input logic [7:0] m);
		rd(ADDR_RES_HI, last_just ? {6'h00, last_res[9:8]} : last_res[9:2], m);
		rd(ADDR_RES_LO, last_just ? last_res[7:0] : {last_res[1:0], 6'h00}, m);
	endtask
	task automatic wait_sample(input int lo, input int hi);
		int n;
		n = 0;
		while (sample_connect_out !== 1'b1 && n < hi) begin
			@(posedge clk_in);
			n++;
		end
		check(n >= lo && n < hi, "acquisition restart time");
	endtask
	task automatic conv(input logic [1:0] src, input logic [2:0] c, input logic just,
		input logic [3:0] cfg, input logic [9:0] v, input logic chk);
		int h;
		int n;
		logic [7:0] ctl;
		h = (src == SRC_DIV2) ? 1 : (src == SRC_DIV8) ? 4 : 16;
		ctl = {src, c, 3'b001};
		wr(ADDR_PORTCFG, {2'b00, just, 1'b0, cfg});
		wr(ADDR_CTRL, ctl);
		repeat (20) @(posedge clk_in);
		wr(ADDR_CTRL, ctl | 8'h04);
		rd(ADDR_CTRL, 8'h05, 8'h05);
		check(dac_code_out === 10'h200, "first trial code");
		n = 2;
		while (conversion_done_flag_out !== 1'b1 && n < 1000) begin
			@(posedge clk_in);
			n++;
		end
		check(n >= 21 * h && n <= 24 * h + 8, "conversion length");
		check(sample_connect_out === 1'b0, "capacitor connected in holdoff");
		wait_sample(2 * h, 5 * h + 8);
		if (chk) begin
			last_res = v;
			last_just = just;
		end
		rd(ADDR_CTRL, 8'h01, 8'h05);
		rd_res(chk ? 8'hFF : 8'h00);
		rd(ADDR_STATUS, {6'h00, src != SRC_RC && 2 * h * CLK_PERIOD_NS < MIN_PERIOD_NS, 1'b1},
			8'h03);
		wr(ADDR_STATUS, 8'h01);
		repeat (2) @(posedge clk_in);
		check(conversion_done_flag_out === 1'b0, "done flag not cleared");
	endtask

	initial begin
		void'($urandom(32'hc4618f4f));
		for (int i = 0; i < 8; i++)
			levels[i * 10 +: 10] = 10'($urandom);
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		ext_pins <= 8'($urandom);
		check(pin_oe_out === 8'h00 && conversion_done_flag_out === 1'b0, "reset outputs");
		rd(ADDR_CTRL, CTRL_RESET, 8'hFF);
		rd(ADDR_PORTCFG, CFG_RESET, 8'hFF);
		rd(ADDR_DIR, DIR_RESET, 8'hFF);
		rd(4'hF, 8'h00, 8'hFF);
		wr(ADDR_CTRL, 8'h04);
		rd(ADDR_CTRL, 8'h00, 8'h05);
		check(powered_out === 1'b0, "powered without power bit");
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_CTRL, {2'h2, 3'(c), 3'b001});
			@(posedge clk_in);
			check(mux_sel_out === 3'(c) && powered_out === 1'b1, "channel select");
		end
		wr(ADDR_PORTCFG, 8'h00);
		repeat (4) @(posedge clk_in);
		rd(ADDR_PORT_RD, 8'h00, 8'hFF);
		wr(ADDR_PORTCFG, 8'h06);
		repeat (4) @(posedge clk_in);
		rd(ADDR_PORT_RD, ext_pins, 8'hFF);
		for (int s = 0; s < 4; s++) begin
			ch = 3'($urandom);
			conv(2'(s), ch, s[0], s == 1 ? 4'h6 : 4'h0, levels[ch * 10 +: 10], s != 0);
		end
		wr(ADDR_DIR, 8'hFB);
		wr(ADDR_PORT_OUT, 8'h04);
		conv(SRC_DIV32, 3'h2, 1'b0, 4'h0, 10'h3FF, 1'b1);
		check(pin_oe_out === 8'h04 && dac_drive_own_out === 1'b1, "own level path");
		wr(ADDR_DIR, DIR_RESET);
		conv(SRC_DIV32, 3'h5, 1'b1, 4'h0, levels[59:50], 1'b1);
		repeat (20) @(posedge clk_in);
		wr(ADDR_CTRL, 8'hAD);
		repeat (100) @(posedge clk_in);
		wr(ADDR_CTRL, 8'hA9);
		@(posedge clk_in);
		check(sample_connect_out === 1'b0, "capacitor connected after abort");
		wait_sample(32, 88);
		repeat (250) @(posedge clk_in);
		check(conversion_done_flag_out === 1'b0, "aborted run completed");
		rd(ADDR_CTRL, 8'h00, 8'h04);
		rd_res(8'hFF);
		// slow start, then a faster oscillator division mid-conversion
		wr(ADDR_CTRL, {SRC_DIV32, 3'h2, 3'b101});
		repeat (100) @(posedge clk_in);
		wr(ADDR_CTRL, {SRC_DIV2, 3'h2, 3'b101});
		while (conversion_done_flag_out !== 1'b1 && fast_n < 100) begin
			@(posedge clk_in);
			fast_n++;
		end
		check(fast_n >= 8 && fast_n <= 24, "shortened conversion length");
		rd(ADDR_STATUS, 8'h03, 8'h03);
		wr(ADDR_STATUS, 8'h01);
		repeat (3) @(posedge clk_in);
		finish_test();
	end
endmodule
`default_nettype wire
